// *** rtl/rsos_pkg.sv ***
// package for the relay status output selector: register map, function codes,
// status flag carrier and timing constants.
// assumes a 20 MHz system clock and a 32-bit apb register bus.
package rsos_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam longint unsigned RSOS_CLK_HZ       = 64'd20_000_000;
    localparam longint unsigned RSOS_PLC_PULSE_MS = 64'd250;   // plc cycle pulse width
    // pulse width in clock cycles, derived from the time and the rate
    localparam int unsigned RSOS_PLC_PULSE_CYC =
        int'((RSOS_PLC_PULSE_MS * RSOS_CLK_HZ) / 64'd1000);
    localparam logic [15:0] RSOS_DRV_OVL_LEAD_MS = 16'd10000; // 10 s lead before drive trip

    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] RSOS_OFF_FUNC_SEL  = 8'h00;
    localparam logic [7:0] RSOS_OFF_RUN_THR   = 8'h04;
    localparam logic [7:0] RSOS_OFF_MOT_THR   = 8'h08;
    localparam logic [7:0] RSOS_OFF_STATE     = 8'h0c;
    localparam logic [7:0] RSOS_OFF_INT_STAT  = 8'h10;
    localparam logic [7:0] RSOS_OFF_INT_MASK  = 8'h14;

    localparam logic [7:0]  RSOS_FUNC_SEL_RST = 8'h02;  // factory setting
    localparam logic [7:0]  RSOS_FUNC_MAX     = 8'h29;  // highest legal code, 41
    localparam logic [15:0] RSOS_RUN_THR_RST  = 16'h0000;
    localparam logic [15:0] RSOS_MOT_THR_RST  = 16'hffff;

    // interrupt status bit positions
    localparam int RSOS_IRQ_W        = 4;
    localparam int RSOS_IRQ_RISE     = 0;   // relay went on
    localparam int RSOS_IRQ_FALL     = 1;   // relay went off
    localparam int RSOS_IRQ_PLC      = 2;   // plc cycle pulse started
    localparam int RSOS_IRQ_BAD_CODE = 3;   // write of a code above 41 refused

    // state register bit positions
    localparam int RSOS_ST_RELAY     = 0;
    localparam int RSOS_ST_PLC_PULSE = 1;
    localparam int RSOS_ST_DRV_PRE   = 2;

    // ------------------------------------------------------------------
    // relay function codes
    // ------------------------------------------------------------------
    localparam logic [5:0] RSOS_F_NONE       = 6'h00;
    localparam logic [5:0] RSOS_F_RUNNING    = 6'h01;
    localparam logic [5:0] RSOS_F_FAULT_STOP = 6'h02;
    localparam logic [5:0] RSOS_F_ZERO_RUN   = 6'h05;
    localparam logic [5:0] RSOS_F_MOT_PRE    = 6'h06;
    localparam logic [5:0] RSOS_F_DRV_PRE    = 6'h07;
    localparam logic [5:0] RSOS_F_PLC_CYCLE  = 6'h0b;
    localparam logic [5:0] RSOS_F_RUN_TIME   = 6'h0c;
    localparam logic [5:0] RSOS_F_FREQ_LIM   = 6'h0d;
    localparam logic [5:0] RSOS_F_TORQ_LIM   = 6'h0e;
    localparam logic [5:0] RSOS_F_READY      = 6'h0f;
    localparam logic [5:0] RSOS_F_RSVD_16    = 6'h10;
    localparam logic [5:0] RSOS_F_UPPER      = 6'h11;
    localparam logic [5:0] RSOS_F_LOWER      = 6'h12;
    localparam logic [5:0] RSOS_F_UNDERVOLT  = 6'h13;
    localparam logic [5:0] RSOS_F_RSVD_21    = 6'h15;
    localparam logic [5:0] RSOS_F_RSVD_22    = 6'h16;
    localparam logic [5:0] RSOS_F_ZERO_ANY   = 6'h17;
    localparam int         RSOS_NUM_CODES    = 42;

    // ------------------------------------------------------------------
    // drive status flags, all from logic on clk_sys
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        running;          // drive running, at any output frequency including zero
        logic        fault_stop;       // stopped because of a fault
        logic        out_freq_zero;    // output frequency equals zero
        logic        set_beyond_limit; // set frequency above upper or below lower limit
        logic        at_upper;         // operating frequency at upper limit
        logic        at_lower;         // operating frequency at lower limit
        logic        speed_mode;       // speed control mode selected
        logic        torque_at_limit;  // output torque at torque limit
        logic        stall_active;     // stall protection active
        logic        main_pwr_ok;      // main circuit supply stable
        logic        ctrl_pwr_ok;      // control circuit supply stable
        logic        fault_seen;       // any fault detected
        logic        run_permit;       // running permitted
        logic        undervolt;        // undervoltage condition
        logic        drv_ovl_active;   // drive overload integrator counting
        logic        plc_cycle_done;   // one-cycle strobe: sequencer finished a cycle
        logic [15:0] drv_ovl_left_ms;  // time left before drive overload trip
        logic [15:0] mot_ovl_level;    // motor overload accumulation level
        logic [15:0] run_time_acc;     // accumulated running time
    } rsos_status_t;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rsos_apb_req_t;

endpackage

// *** rtl/rsos_relay_sel.sv ***
// relay status output selector: picks one drive status condition by a stored
// function code and drives the multi-function relay, with an apb register file.
// assumes all status flags come from logic on clk_sys; the relay pin driver and
// contact sit outside this block.
//
// What this block does
// - function code holds 0 to 41, resets to 2
// - code 0 keeps the relay off always
// - code 1: relay on while running, even at zero output frequency
// - code 2: relay on while stopped by a fault
// - code 5: relay on only running at zero frequency, off when stopped
// - code 6: relay on once motor overload pre-alarm threshold is exceeded
// - code 7: relay on ten seconds before drive overload protection acts
// - code 11: a completed sequencer cycle gives a 250 ms relay pulse; a cycle ending inside a pulse restarts it
// - code 12: relay on once accumulated run time exceeds its threshold
// - code 13: set frequency beyond a limit and output at the upper or the lower limit
// - code 14: speed mode, torque at limit and stall protection active
// - code 15: power stable, no fault, running permitted
// - code 17: relay on while frequency is at upper limit
// - code 18: relay on at lower limit, off when stopped
// - code 19: relay on during undervoltage
// - code 23: relay on whenever output frequency is zero, even stopped
module rsos_relay_sel #(
    parameter int unsigned PLC_PULSE_CYC = rsos_pkg::RSOS_PLC_PULSE_CYC,
    parameter int          CNT_W         = 23,
    parameter logic [41:0] EXT_CONNECTED = 42'h000_0000_0000
) (
    // clock, reset, enable
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // drive status from internal logic
    input  wire rsos_pkg::rsos_status_t drv_status,
    input  wire logic [41:0]           ext_cond,
    // relay and interrupt
    output logic                       relay_output_one,
    output logic                       irq
);
    import rsos_pkg::*;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (PLC_PULSE_CYC < 1 || PLC_PULSE_CYC >= (64'd1 << CNT_W)) begin : g_bad_pulse
        $error("PLC_PULSE_CYC must be at least 1 and fit in CNT_W bits");
    end
    if (EXT_CONNECTED[RSOS_F_RSVD_16] || EXT_CONNECTED[RSOS_F_RSVD_21]
        || EXT_CONNECTED[RSOS_F_RSVD_22]) begin : g_bad_ext
        $error("reserved codes cannot take an external flag");
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]            relay_function_select;
    logic [15:0]           cumulative_run_time_threshold;
    logic [15:0]           mot_prealarm_thr;
    logic [RSOS_IRQ_W-1:0] int_status;
    logic [RSOS_IRQ_W-1:0] int_mask;
    logic [CNT_W-1:0]      plc_cnt;
    logic                  plc_pulse;
    logic                  drv_pre;
    logic                  next_relay;
    logic                  code_ok;
    logic                  bad_code_evt;
    logic                  plc_start_evt;
    logic                  rise_evt;
    logic                  fall_evt;
    logic [RSOS_IRQ_W-1:0] set_vec;
    logic [RSOS_IRQ_W-1:0] clr_vec;
    rsos_apb_req_t         req;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    // one wait state keeps pready, prdata and pslverr straight from flops
    logic acc_done;
    logic wr_fire;
    logic [31:0] rd_mux;
    logic        rd_err;

    assign acc_done = req.psel & req.penable & pready;
    assign wr_fire  = acc_done & req.pwrite & ~pslverr;

    // a code above 41 is never stored; the write answers with an error
    assign code_ok = req.pwdata[7:0] <= RSOS_FUNC_MAX;

    // read mux and error decode for the access in progress
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (req.paddr)
            RSOS_OFF_FUNC_SEL: begin
                rd_mux[7:0] = relay_function_select;
                rd_err      = req.pwrite & ~code_ok;
            end
            RSOS_OFF_RUN_THR:  rd_mux[15:0] = cumulative_run_time_threshold;
            RSOS_OFF_MOT_THR:  rd_mux[15:0] = mot_prealarm_thr;
            RSOS_OFF_STATE: begin
                rd_mux[RSOS_ST_RELAY]     = relay_output_one;
                rd_mux[RSOS_ST_PLC_PULSE] = plc_pulse;
                rd_mux[RSOS_ST_DRV_PRE]   = drv_pre;
            end
            RSOS_OFF_INT_STAT: rd_mux[RSOS_IRQ_W-1:0] = int_status;
            RSOS_OFF_INT_MASK: rd_mux[RSOS_IRQ_W-1:0] = int_mask;
            default:           rd_err = 1'b1;
        endcase
    end

    // answer handshake: pready rises in the second access cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= req.psel & req.penable & ~pready;
            prdata  <= (req.psel & req.penable & ~pready & ~req.pwrite) ? rd_mux : 32'h0000_0000;
            pslverr <= req.psel & req.penable & ~pready & rd_err;
        end
    end

    // software-written configuration
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            relay_function_select         <= RSOS_FUNC_SEL_RST;
            cumulative_run_time_threshold <= RSOS_RUN_THR_RST;
            mot_prealarm_thr              <= RSOS_MOT_THR_RST;
            int_mask                      <= '0;
        end else if (clk_en && wr_fire) begin
            case (req.paddr)
                RSOS_OFF_FUNC_SEL: relay_function_select <= req.pwdata[7:0];
                RSOS_OFF_RUN_THR:  cumulative_run_time_threshold <= req.pwdata[15:0];
                RSOS_OFF_MOT_THR:  mot_prealarm_thr <= req.pwdata[15:0];
                RSOS_OFF_INT_MASK: int_mask <= req.pwdata[RSOS_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // plc cycle pulse stretcher
    // ------------------------------------------------------------------
    // a new cycle strobe during a pulse restarts the full width, so back to
    // back cycles never give a pulse shorter than the set width
    assign plc_start_evt = drv_status.plc_cycle_done;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            plc_cnt   <= '0;
            plc_pulse <= 1'b0;
        end else if (clk_en) begin
            if (plc_start_evt) begin
                plc_cnt   <= CNT_W'(PLC_PULSE_CYC - 1);
                plc_pulse <= 1'b1;
            end else if (plc_cnt != '0) begin
                plc_cnt <= plc_cnt - 1'b1;
            end else begin
                plc_pulse <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // drive overload pre-alarm
    // ------------------------------------------------------------------
    // the overload integrator reports time left; warn once it is inside the lead
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            drv_pre <= 1'b0;
        end else if (clk_en) begin
            drv_pre <= drv_status.drv_ovl_active
                     & (drv_status.drv_ovl_left_ms <= RSOS_DRV_OVL_LEAD_MS);
        end
    end

    // ------------------------------------------------------------------
    // condition selector
    // ------------------------------------------------------------------
    always_comb begin
        code_sel_blk: begin
            logic [5:0] code;
            code = relay_function_select[5:0];
            case (code)
                RSOS_F_NONE:       next_relay = 1'b0;
                RSOS_F_RUNNING:    next_relay = drv_status.running;
                RSOS_F_FAULT_STOP: next_relay = drv_status.fault_stop;
                RSOS_F_ZERO_RUN:   next_relay = drv_status.running
                                              & drv_status.out_freq_zero;
                RSOS_F_MOT_PRE:    next_relay = drv_status.mot_ovl_level
                                              > mot_prealarm_thr;
                RSOS_F_DRV_PRE:    next_relay = drv_pre;
                RSOS_F_PLC_CYCLE:  next_relay = plc_pulse;
                RSOS_F_RUN_TIME:   next_relay = drv_status.run_time_acc
                                              > cumulative_run_time_threshold;
                RSOS_F_FREQ_LIM:   next_relay = drv_status.set_beyond_limit
                                              & (drv_status.at_upper
                                                 | drv_status.at_lower);
                RSOS_F_TORQ_LIM:   next_relay = drv_status.speed_mode
                                              & drv_status.torque_at_limit
                                              & drv_status.stall_active;
                RSOS_F_READY:      next_relay = drv_status.main_pwr_ok
                                              & drv_status.ctrl_pwr_ok
                                              & ~drv_status.fault_seen
                                              & drv_status.run_permit;
                RSOS_F_UPPER:      next_relay = drv_status.at_upper;
                RSOS_F_LOWER:      next_relay = drv_status.at_lower
                                              & drv_status.running;
                RSOS_F_UNDERVOLT:  next_relay = drv_status.undervolt;
                RSOS_F_ZERO_ANY:   next_relay = drv_status.out_freq_zero
                                              | ~drv_status.running;
                RSOS_F_RSVD_16,
                RSOS_F_RSVD_21,
                RSOS_F_RSVD_22:    next_relay = 1'b0;
                default: begin
                    // conditions computed elsewhere come in on ext_cond
                    if (code < 6'(RSOS_NUM_CODES)) begin
                        next_relay = EXT_CONNECTED[code] & ext_cond[code];
                    end else begin
                        next_relay = 1'b0;
                    end
                end
            endcase
        end
    end

    // relay follows the selection every enabled clock
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            relay_output_one <= 1'b0;
        end else if (clk_en) begin
            relay_output_one <= next_relay;
        end
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    assign rise_evt     = next_relay & ~relay_output_one;
    assign fall_evt     = ~next_relay & relay_output_one;
    assign bad_code_evt = acc_done & req.pwrite & (req.paddr == RSOS_OFF_FUNC_SEL) & pslverr;

    always_comb begin
        set_vec                    = '0;
        set_vec[RSOS_IRQ_RISE]     = rise_evt;
        set_vec[RSOS_IRQ_FALL]     = fall_evt;
        set_vec[RSOS_IRQ_PLC]      = plc_start_evt;
        set_vec[RSOS_IRQ_BAD_CODE] = bad_code_evt;
        clr_vec = (wr_fire && req.paddr == RSOS_OFF_INT_STAT) ? req.pwdata[RSOS_IRQ_W-1:0] : '0;
    end

    // write one to clear; a new event in the clearing cycle wins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            int_status <= '0;
        end else if (clk_en) begin
            int_status <= (int_status & ~clr_vec) | set_vec;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(int_status & int_mask);
        end
    end

endmodule

// *** dv/rsos_relay_sel_checker.sv ***
// assertions on the relay selector ports, bound into every rsos_relay_sel
// assumes a function code write lands at the edge where pready is sampled high
module rsos_relay_sel_checker import rsos_pkg::*; #(
    parameter int unsigned PLC_PULSE_CYC = 8
) (
    // clock, reset, enable
    input wire logic         clk_sys,
    input wire logic         rst_n,
    input wire logic         clk_en,
    // apb
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata,
    input wire logic         pready,
    input wire logic         pslverr,
    // status and relay
    input wire rsos_status_t drv_status,
    input wire logic         relay_output_one
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [7:0]  sel;
    logic [31:0] run_len;
    // shadow of the stored code: refused writes must not move it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) sel <= RSOS_FUNC_SEL_RST;
        else if (clk_en && psel && penable && pready && pwrite && !pslverr && paddr == RSOS_OFF_FUNC_SEL)
            sel <= pwdata[7:0];
    end
    // length of the current relay closure, frozen while the clock enable is low
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !relay_output_one) run_len <= 32'd0;
        else if (clk_en) run_len <= run_len + 32'd1;
    end
    chk_zero_off: assert property (clk_en && sel == 8'h00 |=> !relay_output_one)
        else $error("relay on with code zero");
    chk_run_follow: assert property (clk_en && sel == 8'h01 |=> relay_output_one == $past(drv_status.running))
        else $error("relay does not follow running");
    chk_fault_follow: assert property (clk_en && sel == 8'h02 |=> relay_output_one == $past(drv_status.fault_stop))
        else $error("relay does not follow fault stop");
    chk_zero_run: assert property (clk_en && sel == 8'h05 |=>
        relay_output_one == $past(drv_status.running && drv_status.out_freq_zero)) else $error("zero speed run wrong");
    chk_undervolt: assert property (clk_en && sel == 8'h13 |=> relay_output_one == $past(drv_status.undervolt))
        else $error("relay does not follow undervoltage");
    chk_zero_any: assert property (clk_en && sel == 8'h17 |=>
        relay_output_one == $past(drv_status.out_freq_zero || !drv_status.running)) else $error("zero speed any wrong");
    chk_rsvd_off: assert property (clk_en && sel inside {8'h10, 8'h15, 8'h16} |=> !relay_output_one)
        else $error("relay on with reserved code");
    chk_bad_code: assert property (psel && penable && pready && pwrite && paddr == RSOS_OFF_FUNC_SEL
        && pwdata[7:0] > RSOS_FUNC_MAX |-> pslverr) else $error("code above range accepted");
    chk_one_wait: assert property (clk_en && psel && penable && !pready |=> pready)
        else $error("apb answer late");
    chk_plc_width: assert property (clk_en && sel == 8'h0b && $fell(relay_output_one) |->
        run_len == PLC_PULSE_CYC) else $error("plc pulse width wrong");
endmodule

bind rsos_relay_sel rsos_relay_sel_checker #(.PLC_PULSE_CYC(PLC_PULSE_CYC)) chk_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .drv_status(drv_status),
    .relay_output_one(relay_output_one));

// *** dv/rsos_relay_contact.sv ***
// model of the equipment on the relay contact: closes one clock after the coil
// and keeps the length of the last closure, in clocks, for the bench to read
module rsos_relay_contact (
    input wire logic   clk_sys,
    input wire logic   relay_output_one,
    output logic       contact_closed,
    output int unsigned last_on_cyc
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned run_cyc;
    // width is latched when the contact opens, so a held closure never reports
    always_ff @(posedge clk_sys) begin
        contact_closed <= relay_output_one;
        if (relay_output_one) run_cyc <= run_cyc + 1;
        else begin
            if (run_cyc != 0) last_on_cyc <= run_cyc;
            run_cyc <= 0;
        end
    end
endmodule

// *** dv/test_relay_status_output_selector.sv ***
// self-checking bench for the relay selector: apb tasks plus a condition table
// assumes the pulse parameter shortened to 8 clocks and code 20 externally connected
module test_relay_status_output_selector import rsos_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk_sys, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, relay_output_one, irq;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [41:0]  ext_cond;
    rsos_status_t drv_status;
    int unsigned  last_on_cyc;
    int           n_errors, n_tests;

    rsos_relay_sel #(.PLC_PULSE_CYC(8), .EXT_CONNECTED(42'h000_0010_0000)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .drv_status(drv_status), .ext_cond(ext_cond), .relay_output_one(relay_output_one), .irq(irq));
    rsos_relay_contact contact_u (.clk_sys(clk_sys), .relay_output_one(relay_output_one),
        .contact_closed(), .last_on_cyc(last_on_cyc));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic wrap_up;
        if (n_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; waits as long as the slave needs, a dead slave meets the watchdog
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        check({31'd0, pslverr}, {31'd0, err}, "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // set the status word, select a code, let the relay settle, compare
    task automatic cond(input logic [5:0] code, input logic exp, input logic [15:0] fl = 16'h0000,
                        input logic [15:0] left = 16'hffff, input logic [15:0] mot = 16'h0000,
                        input logic [15:0] run = 16'h0000);
        drv_status <= {fl, left, mot, run};
        apb(1'b1, RSOS_OFF_FUNC_SEL, {26'd0, code}, 1'b0);
        repeat (4) @(posedge clk_sys);
        check({31'd0, relay_output_one}, {31'd0, exp}, "relay");
    endtask

    initial begin
        n_errors = 0;
        n_tests = 0;
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        clk_en = 1'b1;
        ext_cond = '1;
        drv_status = '0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, RSOS_OFF_FUNC_SEL, 32'h0, 1'b0);
        check(rd, 32'h2, "code after reset");
        apb(1'b0, RSOS_OFF_MOT_THR, 32'h0, 1'b0);
        check(rd, 32'hffff, "motor threshold");
        apb(1'b0, 8'h20, 32'h0, 1'b1);
        apb(1'b1, RSOS_OFF_FUNC_SEL, 32'h2a, 1'b1);
        apb(1'b0, RSOS_OFF_FUNC_SEL, 32'h0, 1'b0);
        check(rd, 32'h2, "refused code");
        apb(1'b1, RSOS_OFF_FUNC_SEL, 32'h29, 1'b0);
        apb(1'b0, RSOS_OFF_FUNC_SEL, 32'h0, 1'b0);
        check(rd, 32'h29, "top code");
        apb(1'b1, RSOS_OFF_MOT_THR, 32'h100, 1'b0);
        apb(1'b1, RSOS_OFF_RUN_THR, 32'h10, 1'b0);
        // condition table, codes 1, 5, 6, 7, 12 to 15, 18, 20 and 23 from both sides
        cond(6'h00, 1'b0, 16'hfffe);
        cond(6'h01, 1'b1, 16'ha000);
        cond(6'h01, 1'b0, 16'h2000);
        cond(6'h02, 1'b1, 16'h4000);
        cond(6'h05, 1'b1, 16'ha000);
        cond(6'h05, 1'b0, 16'h2000);
        cond(6'h06, 1'b1, 16'h0000, 16'hffff, 16'h0101);
        cond(6'h06, 1'b0, 16'h0000, 16'hffff, 16'h0100);
        cond(6'h07, 1'b1, 16'h0002, 16'h2710);
        cond(6'h07, 1'b0, 16'h0002, 16'h2711);
        cond(6'h0c, 1'b1, 16'h0000, 16'hffff, 16'h0000, 16'h0011);
        cond(6'h0c, 1'b0, 16'h0000, 16'hffff, 16'h0000, 16'h0010);
        cond(6'h0d, 1'b1, 16'h1800);
        cond(6'h0d, 1'b0, 16'h0800);
        cond(6'h0e, 1'b1, 16'h0380);
        cond(6'h0e, 1'b0, 16'h0180);
        cond(6'h0f, 1'b1, 16'h0068);
        cond(6'h0f, 1'b0, 16'h0078);
        cond(6'h11, 1'b1, 16'h0800);
        cond(6'h12, 1'b1, 16'h8400);
        cond(6'h12, 1'b0, 16'h0400);
        cond(6'h13, 1'b1, 16'h0004);
        cond(6'h17, 1'b1, 16'h0000);
        cond(6'h17, 1'b0, 16'h8000);
        cond(6'h10, 1'b0, 16'hfffe);
        cond(6'h15, 1'b0, 16'hfffe);
        cond(6'h16, 1'b0, 16'hfffe);
        cond(6'h14, 1'b1);
        ext_cond <= '0;
        cond(6'h14, 1'b0);
        cond(6'h03, 1'b0);
        // a low enable freezes the relay even though running has dropped
        cond(6'h01, 1'b1, 16'h8000);
        clk_en <= 1'b0;
        drv_status <= '0;
        repeat (3) @(posedge clk_sys);
        check({31'd0, relay_output_one}, 32'h1, "frozen relay");
        clk_en <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check({31'd0, relay_output_one}, 32'h0, "released relay");
        // one sequencer cycle gives one pulse, raising the unmasked interrupt
        cond(6'h0b, 1'b0);
        apb(1'b1, RSOS_OFF_INT_STAT, 32'hf, 1'b0);
        apb(1'b1, RSOS_OFF_INT_MASK, 32'h4, 1'b0);
        drv_status <= {16'h0001, 16'hffff, 32'h0};
        @(posedge clk_sys);
        drv_status <= '0;
        repeat (20) @(posedge clk_sys);
        check(last_on_cyc, 32'd8, "pulse width");
        check({31'd0, irq}, 32'h1, "irq raised");
        apb(1'b0, RSOS_OFF_INT_STAT, 32'h0, 1'b0);
        check(rd, 32'h7, "event status");
        apb(1'b1, RSOS_OFF_INT_MASK, 32'h0, 1'b0);
        repeat (2) @(posedge clk_sys);
        check({31'd0, irq}, 32'h0, "irq masked");
        apb(1'b1, RSOS_OFF_INT_MASK, 32'h4, 1'b0);
        apb(1'b1, RSOS_OFF_INT_STAT, 32'h7, 1'b0);
        repeat (2) @(posedge clk_sys);
        check({31'd0, irq}, 32'h0, "irq cleared");
        // second reset in mid-run restores the factory code
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, RSOS_OFF_FUNC_SEL, 32'h0, 1'b0);
        check(rd, 32'h2, "code after second reset");
        wrap_up();
    end

    // watchdog: the whole run needs well under 2000 clocks
    initial begin
        #(50 * 5000);
        n_errors++;
        wrap_up();
    end
endmodule
